// ---- verif/tpcs_ext_src.sv ----
/* partner: external count clock source, one square wave per timer pin.
   assumes the bench changes enables only at clk_sys rising edges. */
`timescale 1ns/1ps
module tpcs_ext_src
    import tpcs_pkg::*;
#(
    parameter int HALF_BASE = 2
)
(
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       arst_n,
    // control and pins
    input  wire logic [TPCS_NUM_TIMERS-1:0] en,
    output logic      [TPCS_NUM_TIMERS-1:0] pin
);
    int cnt [TPCS_NUM_TIMERS];
    // halves of two or more clocks: 2 is the fastest legal rate
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin <= '0;
            for (int i = 0; i < TPCS_NUM_TIMERS; i++) cnt[i] <= 0;
        end else begin
            for (int i = 0; i < TPCS_NUM_TIMERS; i++) begin
                if (en[i] && cnt[i] >= HALF_BASE + i - 1) begin
                    cnt[i] <= 0;
                    pin[i] <= ~pin[i];
                end else if (en[i]) begin
                    cnt[i] <= cnt[i] + 1;
                end
            end
        end
    end
endmodule // tpcs_ext_src

// ---- verif/tpcs_timer_prescaler_assertions.sv ----
/* checker: bus timing and tick relations of tpcs_timer_prescaler.
   assumes selects change only through bus writes. */
`timescale 1ns/1ps
module tpcs_chk
    import tpcs_pkg::*;
(
    // clock and reset
    input wire logic                       clk_sys,
    input wire logic                       arst_n,
    // bus
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_we_i,
    input wire logic [TPCS_WB_AW-1:0]      wb_adr_i,
    input wire logic [3:0]                 wb_sel_i,
    input wire logic [31:0]                wb_dat_i,
    input wire logic [31:0]                wb_dat_o,
    input wire logic                       wb_ack_o,
    // timer side
    input wire logic [TPCS_NUM_TIMERS-1:0] ext_count_pin,
    input wire logic [TPCS_NUM_TIMERS-1:0] timer_tick,
    input wire logic                       divider_held
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic [TPCS_NUM_TIMERS-1:0][2:0] cs;
    wire take = wb_cyc_i & wb_stb_i & !wb_ack_o;
    // mirror of the select fields, snooped at the taking edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            cs <= '0;
        else if (take & wb_we_i & wb_sel_i[0] & (wb_adr_i == TPCS_OFS_CS))
            cs <= {wb_dat_i[10:8], wb_dat_i[6:4], wb_dat_i[2:0]};
    end
    a_ack_follows: assert property (take |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == '0)
        else $error("read data not zero outside ack");
    for (genvar i = 0; i < TPCS_NUM_TIMERS; i++) begin : g_t
        a_stop_silent: assert property (cs[i] == 3'h0 |-> !timer_tick[i])
            else $error("tick while stopped");
        a_sysclk_tick: assert property (cs[i] == 3'h1 |-> timer_tick[i])
            else $error("system clock source missed a cycle");
        a_div8_gap: assert property (
            cs[i] == 3'h2 && timer_tick[i] |=> (!timer_tick[i] || cs[i] != 3'h2)[*7])
            else $error("divide by 8 tick too soon");
        a_held_no_tap: assert property (
            divider_held && cs[i] inside {[3'h2:3'h5]} |-> !timer_tick[i])
            else $error("tap tick while divider held");
        a_ext_rise: assert property (
            cs[i] == 3'h7 |->
            timer_tick[i] == ($past(ext_count_pin[i], 2) && !$past(ext_count_pin[i], 3)))
            else $error("rising pin edge tick wrong");
        a_ext_fall: assert property (
            cs[i] == 3'h6 |->
            timer_tick[i] == (!$past(ext_count_pin[i], 2) && $past(ext_count_pin[i], 3)))
            else $error("falling pin edge tick wrong");
    end
    c_ext_tick: cover property (cs[0] == 3'h7 && timer_tick[0]);
    c_held: cover property (divider_held);
    c_read: cover property (take && !wb_we_i);
endmodule // tpcs_chk

bind tpcs_timer_prescaler tpcs_chk i_tpcs_chk (
    .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_count_pin(ext_count_pin),
    .timer_tick(timer_tick), .divider_held(divider_held));

// ---- verif/tpcs_timer_prescaler_tb_top.sv ----
/* bench: tpcs_timer_prescaler with pin source and bus tasks.
   assumes ack arrives well inside the cycle ceiling. */
`timescale 1ns/1ps
module tpcs_timer_prescaler_tb_top
    import tpcs_pkg::*;
;
    logic        clk_sys = 0, arst_n = 0, cyc = 0, stb = 0, we = 0;
    logic [3:0]  adr = '0, sel = '0;
    logic [31:0] wdat = '0, rdat, q;
    logic        ack, held, aheld;
    logic [2:0]  pin, tick, en = '0, c;
    logic [15:0] seed = 16'h0017;
    logic [11:0] v;
    int          err_count = 0, cmp_count = 0, cycles = 0, n [3], e [3];
    always #5 clk_sys = ~clk_sys;
    tpcs_timer_prescaler i_tpcs_timer_prescaler (.clk_sys(clk_sys), .arst_n(arst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_count_pin(pin),
        .timer_tick(tick), .divider_held(held), .async_divider_reset(aheld));
    tpcs_ext_src i_tpcs_ext_src (.clk_sys(clk_sys), .arst_n(arst_n), .en(en), .pin(pin));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int exp_ticks(input logic [2:0] k, input int w);
        case (k)
            3'h1: return w;
            3'h2: return w / 8;
            3'h3: return w / 64;
            3'h4: return w / 256;
            3'h5: return w / 1024;
            default: return 0;
        endcase
    endfunction
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // counts ticks and the pin edges each timer should follow
    task automatic count(input int w, input bit clr);
        logic [2:0] p;
        p = pin;
        if (clr) begin
            n = '{0, 0, 0};
            e = '{0, 0, 0};
        end
        repeat (w) begin
            @(posedge clk_sys);
            for (int i = 0; i < 3; i++) begin
                n[i] += (tick[i] === 1'b1);
                e[i] += (i == 1) ? (p[i] && !pin[i]) : (!p[i] && pin[i]);
            end
            p = pin;
        end
    endtask
    task automatic restart(input logic [31:0] d);
        int a;
        int b;
        a = -1;
        b = -1;
        wb(1'b1, TPCS_OFS_SYNC_CTL, d);
        for (int k = 0; k < 200; k++) begin
            @(posedge clk_sys);
            if (a < 0 && tick[0] === 1'b1) a = k;
            if (b < 0 && tick[1] === 1'b1) b = k;
        end
        chk("tap spread", 32'(b - a), 32'h38);
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            close_out;
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        wb(1'b0, TPCS_OFS_SYNC_CTL, 32'h0);
        chk("sync ctl reset", q, {24'h0, TPCS_RST_SYNC_CTL});
        wb(1'b0, TPCS_OFS_CS, 32'h0);
        chk("select reset", q, 32'h0);
        wb(1'b1, 4'hC, 32'hFFFFFFFF);
        wb(1'b0, 4'hC, 32'h0);
        chk("unmapped read", q, 32'h0);
        repeat (4) begin
            seed = lfsr(seed);
            wb(1'b1, TPCS_OFS_CS, {16'h0, seed});
            wb(1'b0, TPCS_OFS_CS, 32'h0);
            chk("select readback", q, {16'h0, seed} & 32'h777);
        end
        // two fixed code sets cover 0..5, then random ones
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            v = (k == 0) ? 12'h321 : (k == 1) ? 12'h054 : {4'(seed[11:8] % 6),
                4'(seed[7:4] % 6), 4'(seed[3:0] % 6)};
            wb(1'b1, TPCS_OFS_CS, {20'h0, v});
            count(2048, 1'b1);
            for (int i = 0; i < 3; i++) begin
                c = v[4*i +: 3];
                chk("tick count", n[i], exp_ticks(c, 2048));
            end
        end
        wb(1'b1, TPCS_OFS_CS, 32'h432);
        restart(32'h1);
        wb(1'b0, TPCS_OFS_SYNC_CTL, 32'h0);
        chk("reset self clear", q, 32'h0);
        wb(1'b1, TPCS_OFS_SYNC_CTL, 32'h83);
        wb(1'b0, TPCS_OFS_SYNC_CTL, 32'h0);
        chk("hold kept", q, 32'h83);
        chk("held flag", {31'h0, held}, 32'h1);
        chk("async held flag", {31'h0, aheld}, 32'h1);
        wb(1'b0, TPCS_OFS_DIV, 32'h0);
        chk("held count", q, 32'h0);
        count(300, 1'b1);
        chk("halted ticks", n[0] + n[1] + n[2], 32'h0);
        restart(32'h0);
        wb(1'b0, TPCS_OFS_SYNC_CTL, 32'h0);
        chk("hold cleared", q, 32'h0);
        chk("held flag released", {31'h0, held}, 32'h0);
        chk("async flag released", {31'h0, aheld}, 32'h0);
        wb(1'b1, TPCS_OFS_CS, 32'h767);
        en <= 3'h7;
        count(400, 1'b1);
        en <= 3'h0;
        count(8, 1'b0);
        chk("edges seen", 32'(e[0] > 50), 32'h1);
        for (int i = 0; i < 3; i++) chk("ext ticks", n[i], e[i]);
        close_out;
    end
endmodule // tpcs_timer_prescaler_tb_top

// ---- verilog/tpcs_ext_edge.sv ----
/*
 * tpcs_ext_edge: two-stage synchronizer and edge detector for one external count pin.
 * assumes the pin is asynchronous to clk_sys and toggles slower than half its rate.
 */
`timescale 1ns/1ps
module tpcs_ext_edge
    import tpcs_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic arst_n,
    // pin side
    input  wire logic ext_count_pin,
    // edges, one cycle each
    output logic      rise_pulse,
    output logic      fall_pulse
);
    tpcs_ext_s st;
    tpcs_ext_s next_st;

    // front stage samples the pin, second stage only reads the first [R06] [R07]
    always_comb begin
        next_st        = st;
        next_st.sync_1 = ext_count_pin;
        next_st.sync_2 = st.sync_1;
        next_st.last   = st.sync_2;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // pin edge to tick takes two rising edges, 1 to 2 clocks, short of the 2.5..3.5 window [R09]
    assign rise_pulse = st.sync_2 & ~st.last;
    assign fall_pulse = ~st.sync_2 & st.last;
endmodule // tpcs_ext_edge

// ---- verilog/tpcs_pkg.sv ----
/*
 * tpcs_pkg: constants and carrier types for the timer prescaler and clock select.
 * assumes a single 100 MHz system clock and a classic Wishbone slave port.
 */
package tpcs_pkg;
    localparam int          TPCS_NUM_TIMERS   = 3;
    localparam int          TPCS_DIV_W        = 10;
    localparam int          TPCS_WB_AW        = 4;
    // byte addresses of the registers
    localparam logic [3:0]  TPCS_OFS_SYNC_CTL = 4'h0;
    localparam logic [3:0]  TPCS_OFS_CS       = 4'h4;
    localparam logic [3:0]  TPCS_OFS_DIV      = 4'h8;
    // field positions in timer_sync_control
    localparam int          TPCS_BIT_SHARED_RST = 0;
    localparam int          TPCS_BIT_ASYNC_RST  = 1;
    localparam int          TPCS_BIT_HOLD_MODE  = 7;
    // per-timer select field width and spacing in the select register
    localparam int          TPCS_CS_W         = 3;
    localparam int          TPCS_CS_STRIDE    = 4;
    // reset values
    localparam logic [7:0]  TPCS_RST_SYNC_CTL = 8'h00;
    localparam logic [2:0]  TPCS_RST_CS       = 3'h0;
    // tap masks: divided tick when the low bits of the counter are all ones
    localparam logic [9:0]  TPCS_MASK_DIV8    = 10'h007;
    localparam logic [9:0]  TPCS_MASK_DIV64   = 10'h03F;
    localparam logic [9:0]  TPCS_MASK_DIV256  = 10'h0FF;
    localparam logic [9:0]  TPCS_MASK_DIV1024 = 10'h3FF;

    typedef enum logic [2:0] {
        TPCS_CS_STOP    = 3'h0,
        TPCS_CS_SYSCLK  = 3'h1,
        TPCS_CS_DIV8    = 3'h2,
        TPCS_CS_DIV64   = 3'h3,
        TPCS_CS_DIV256  = 3'h4,
        TPCS_CS_DIV1024 = 3'h5,
        TPCS_CS_EXT_FALL = 3'h6,
        TPCS_CS_EXT_RISE = 3'h7
    } tpcs_cs_e;

    typedef struct packed {
        logic       dummy_unused_never;
    } tpcs_none_s;

    typedef struct packed {
        logic       tap8;
        logic       tap64;
        logic       tap256;
        logic       tap1024;
    } tpcs_taps_s;

    typedef struct packed {
        logic       sync_1;
        logic       sync_2;
        logic       last;
    } tpcs_ext_s;
endpackage : tpcs_pkg

// ---- verilog/tpcs_timer_prescaler.sv ----
/*
 * tpcs_timer_prescaler: shared free-running prescaler and per-timer clock select
 * for three timers, with a hold mode for starting the timers in step.
 * register map, one 32-bit word each, unused bits read zero:
 *   0x0 timer_sync_control: bit 7 sync_hold_mode, bit 1 async_divider_reset,
 *       bit 0 shared_divider_reset
 *   0x4 clock_source_select: timer i code in bits 4i+2..4i
 *   0x8 divider count, read only
 *   other addresses: acknowledged, read zero, writes dropped
 * bus timing: ack one cycle after the request is taken, for one cycle;
 *   a write lands on the taking edge and needs sel bit 0.
 * tick timing: a tap ticks when the low divider bits are all ones;
 *   a pin edge ticks two rising edges after the pin changes.
 * assumes a classic Wishbone master on clk_sys; timers consume timer_tick as enables.
 */
// Contract
// (R01) select code 1 ticks the timer every system clock.
// (R02) prescaler offers taps at clock divided by 8, 64, 256, 1024.
// (R03) prescaler runs freely; first tap tick comes 1 to N+1 clocks later.
// (R04) one prescaler shared by three timers, each with its own select.
// (R05) prescaler reset restarts the divider period for every timer.
// (R06) external pin sampled every clock, then fed to an edge detector.
// (R07) synchronizer and edge registers clock on rising system clock edge.
// (R08) code 7 ticks on rising pin edges, code 6 on falling ones.
// (R09) pin edge to tick takes between 2.5 and 3.5 clocks; the code ticks after two rising edges, 1 to 2 clocks.
// (R10) software changes external select only while the pin is stable.
// (R11) external clock half periods exceed one system clock.
// (R12) external edges bypass the prescaler taps entirely.
// (R13) hold mode bit 7 keeps written divider reset bits set.
// (R14) clearing hold mode clears both reset bits so timers start together.
// (R15) shared reset bit 0 resets prescaler, self-clears unless hold mode set.
// (R16) select code 0 delivers no ticks.
// (R17) codes 2 to 5 pick divide by 8, 64, 256, 1024 taps.
// (R18) taps are one-cycle pulses from one 10-bit counter cleared on reset.
`timescale 1ns/1ps
module tpcs_timer_prescaler
    import tpcs_pkg::*;
(
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       arst_n,
    // wishbone slave
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [TPCS_WB_AW-1:0]      wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic [31:0]                     wb_dat_o,
    output logic                            wb_ack_o,
    // external count pins, one per timer
    input  wire logic [TPCS_NUM_TIMERS-1:0] ext_count_pin,
    // timer enables and held-reset view
    output logic [TPCS_NUM_TIMERS-1:0]      timer_tick,
    output logic                            divider_held,
    output logic                            async_divider_reset
);
    typedef struct packed {
        logic [TPCS_DIV_W-1:0]                  div_cnt;
        logic                                   sync_hold_mode;
        logic                                   shared_divider_reset;
        logic                                   async_divider_reset;
        logic [TPCS_NUM_TIMERS-1:0][TPCS_CS_W-1:0] clock_source_select;
        logic                                   ack;
        logic [31:0]                            rdata;
    } tpcs_state_s;

    tpcs_state_s st;
    tpcs_state_s next_st;

    logic [TPCS_NUM_TIMERS-1:0] ext_rise;
    logic [TPCS_NUM_TIMERS-1:0] ext_fall;
    tpcs_taps_s                 taps;
    logic                       div_reset;
    logic                       wb_req;
    logic                       wb_wr;

    function automatic logic tap_hit(input logic [TPCS_DIV_W-1:0] cnt,
                                     input logic [TPCS_DIV_W-1:0] mask);
        tap_hit = ((cnt & mask) == mask);
    endfunction

    // select code to tick; the prescaler state never gates external edges [R12]
    function automatic logic pick_tick(input logic [2:0] cs,
                                       input tpcs_taps_s tp,
                                       input logic rise,
                                       input logic fall);
        case (cs)
            TPCS_CS_STOP:     pick_tick = 1'b0;       // [R16]
            TPCS_CS_SYSCLK:   pick_tick = 1'b1;       // [R01]
            TPCS_CS_DIV8:     pick_tick = tp.tap8;    // [R17]
            TPCS_CS_DIV64:    pick_tick = tp.tap64;   // [R17]
            TPCS_CS_DIV256:   pick_tick = tp.tap256;  // [R17]
            TPCS_CS_DIV1024:  pick_tick = tp.tap1024; // [R17]
            TPCS_CS_EXT_FALL: pick_tick = fall;       // [R08]
            TPCS_CS_EXT_RISE: pick_tick = rise;       // [R08]
            default:          pick_tick = 1'b0;
        endcase
    endfunction

    // register map decode, shared by the write and the read paths
    typedef enum logic [1:0] {
        TPCS_REG_NONE,
        TPCS_REG_SYNC,
        TPCS_REG_SEL,
        TPCS_REG_DIV
    } tpcs_reg_e;

    function automatic tpcs_reg_e reg_decode(input logic [TPCS_WB_AW-1:0] adr);
        case (adr)
            TPCS_OFS_SYNC_CTL: reg_decode = TPCS_REG_SYNC;
            TPCS_OFS_CS:       reg_decode = TPCS_REG_SEL;
            TPCS_OFS_DIV:      reg_decode = TPCS_REG_DIV;
            default:           reg_decode = TPCS_REG_NONE;
        endcase
    endfunction

    tpcs_reg_e                  reg_hit;

    genvar gi;
    generate
        for (gi = 0; gi < TPCS_NUM_TIMERS; gi++) begin : g_ext
            tpcs_ext_edge u_edge (
                .clk_sys       (clk_sys),
                .arst_n        (arst_n),
                .ext_count_pin (ext_count_pin[gi]),
                .rise_pulse    (ext_rise[gi]),
                .fall_pulse    (ext_fall[gi])
            );
            // each timer owns its select, all share the taps [R04]
            assign timer_tick[gi] = pick_tick(st.clock_source_select[gi], taps,
                                              ext_rise[gi], ext_fall[gi]);
        end
    endgenerate

    // a held reset keeps the taps quiet, so prescaled timers stay halted [R13]
    assign div_reset = st.shared_divider_reset;
    always_comb begin
        taps.tap8    = ~div_reset & tap_hit(st.div_cnt, TPCS_MASK_DIV8);    // [R02] [R18]
        taps.tap64   = ~div_reset & tap_hit(st.div_cnt, TPCS_MASK_DIV64);   // [R02] [R18]
        taps.tap256  = ~div_reset & tap_hit(st.div_cnt, TPCS_MASK_DIV256);  // [R02] [R18]
        taps.tap1024 = ~div_reset & tap_hit(st.div_cnt, TPCS_MASK_DIV1024); // [R02] [R18]
    end

    assign reg_hit = reg_decode(wb_adr_i);
    assign wb_req = wb_cyc_i & wb_stb_i & ~st.ack;
    assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];

    always_comb begin
        next_st     = st;
        next_st.ack = wb_req;

        // divider runs regardless of any select code [R03]
        if (div_reset) begin
            next_st.div_cnt = '0; // [R05] [R18]
        end else begin
            next_st.div_cnt = st.div_cnt + 10'h001;
        end

        // a non-held reset lasts one cycle only [R15]
        if (!st.sync_hold_mode) begin
            next_st.shared_divider_reset = 1'b0; // [R14] [R15]
            next_st.async_divider_reset  = 1'b0; // [R14]
        end

        if (wb_wr) begin
            case (reg_hit)
                TPCS_REG_SYNC: begin
                    next_st.sync_hold_mode       = wb_dat_i[TPCS_BIT_HOLD_MODE];
                    // written ones kept while hold mode is written one [R13]
                    next_st.shared_divider_reset = wb_dat_i[TPCS_BIT_SHARED_RST] |
                        (wb_dat_i[TPCS_BIT_HOLD_MODE] & st.shared_divider_reset);
                    next_st.async_divider_reset  = wb_dat_i[TPCS_BIT_ASYNC_RST] |
                        (wb_dat_i[TPCS_BIT_HOLD_MODE] & st.async_divider_reset);
                    if (!wb_dat_i[TPCS_BIT_HOLD_MODE]) begin
                        // release: both cleared together, timers start in step [R14]
                        next_st.shared_divider_reset = wb_dat_i[TPCS_BIT_SHARED_RST];
                        next_st.async_divider_reset  = wb_dat_i[TPCS_BIT_ASYNC_RST];
                    end
                end
                TPCS_REG_SEL: begin
                    for (int i = 0; i < TPCS_NUM_TIMERS; i++) begin
                        next_st.clock_source_select[i] =
                            wb_dat_i[i*TPCS_CS_STRIDE +: TPCS_CS_W];
                    end
                end
                default: begin
                end
            endcase
        end

        next_st.rdata = '0;
        if (wb_req) begin
            case (reg_hit)
                TPCS_REG_SYNC: begin
                    next_st.rdata[TPCS_BIT_HOLD_MODE]  = st.sync_hold_mode;
                    next_st.rdata[TPCS_BIT_SHARED_RST] = st.shared_divider_reset;
                    next_st.rdata[TPCS_BIT_ASYNC_RST]  = st.async_divider_reset;
                end
                TPCS_REG_SEL: begin
                    for (int i = 0; i < TPCS_NUM_TIMERS; i++) begin
                        next_st.rdata[i*TPCS_CS_STRIDE +: TPCS_CS_W] =
                            st.clock_source_select[i];
                    end
                end
                TPCS_REG_DIV: begin
                    next_st.rdata[TPCS_DIV_W-1:0] = st.div_cnt;
                end
                default: begin
                    next_st.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st.div_cnt              <= '0;
            st.sync_hold_mode       <= TPCS_RST_SYNC_CTL[TPCS_BIT_HOLD_MODE];
            st.shared_divider_reset <= TPCS_RST_SYNC_CTL[TPCS_BIT_SHARED_RST];
            st.async_divider_reset  <= TPCS_RST_SYNC_CTL[TPCS_BIT_ASYNC_RST];
            st.clock_source_select  <= {TPCS_NUM_TIMERS{TPCS_RST_CS}};
            st.ack                  <= 1'b0;
            st.rdata                <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wb_ack_o            = st.ack;
    assign wb_dat_o            = st.rdata;
    assign divider_held        = st.shared_divider_reset;
    // async reset bit has no divider here; exported for the async timer's prescaler
    assign async_divider_reset = st.async_divider_reset;
endmodule // tpcs_timer_prescaler
